// ===== verilog/sidc_pkg.sv
// constants, field layout and state types for the sync input delay control
// assumes a 100 MHz core clock and an AXI4-Lite register bus
package sidc_pkg;

  // core clock and delay line figures
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned TAP_COUNT     = 512;
  localparam int unsigned TAP_MIN_PS    = 1250;
  localparam int unsigned TAP_MAX_PS    = 7600;

  // register map, byte addresses
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // field positions inside the control word
  localparam int unsigned SE_CYC_LSB   = 28;
  localparam int unsigned SE_TAP_LSB   = 16;
  localparam int unsigned DIFF_CYC_LSB = 12;
  localparam int unsigned LOAD_BIT     = 9;
  localparam int unsigned DIFF_TAP_LSB = 0;
  localparam logic [31:0] RSV_MASK     = 32'hce00_cc00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // all state of the block, registered in one place
  typedef struct packed {
    logic [31:0] ctrl;
    logic        awrdy;
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        wrdy;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        load_q;
    logic        load;
    logic [8:0]  tap_diff;
    logic [8:0]  tap_se;
    logic [1:0]  s_diff;
    logic [1:0]  s_se;
    logic [2:0]  h_diff;
    logic [2:0]  h_se;
    logic        out_diff;
    logic        out_se;
  } sidc_state_type;

endpackage

// ===== verilog/sidc_top.sv
// sync input delay control: one control word over AXI4-Lite, tap counts and
// a load strobe toward two external delay lines, and a whole-cycle delay on
// the two delayed sync inputs that come back from those lines.
// assumes the delay lines sit outside; their outputs are asynchronous here.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module sidc_top
  import sidc_pkg::*;
#(
  parameter int unsigned TAP_STEPS = TAP_COUNT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sync_diff_tapped,
  input  wire logic              sync_se_tapped,
  output logic [8:0]             tap_diff_value,
  output logic [8:0]             tap_se_value,
  output logic                   tap_load_strobe,
  output logic                   pulse_per_second_diff,
  output logic                   pulse_per_second_se
);

  // the tap fields are 9 bits wide, so the delay line must have 512 steps
  generate
    if (TAP_STEPS != TAP_COUNT) begin : g_bad_taps
      $error("sidc_top: TAP_STEPS must be 512");
    end
  endgenerate

  sidc_state_type st_r;
  sidc_state_type st_nxt;

  // only the one control word is mapped; word alignment is required
  function automatic logic addr_hit(input logic [7:0] a);
    return a == CTRL_OFFSET;
  endfunction

  // byte-lane merge of a write, reserved bits forced back to zero
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v & ~RSV_MASK;
  endfunction

  // pick the synchronised level now or 1..3 cycles back
  function automatic logic pick(input logic       now,
                                input logic [2:0] hist,
                                input logic [1:0] cyc);
    logic v;
    case (cyc)
      2'h0:    v = now;
      2'h1:    v = hist[0];
      2'h2:    v = hist[1];
      2'h3:    v = hist[2];
      default: v = now;
    endcase
    return v;
  endfunction

  // next-state logic: bus slave, load detection, cycle delay
  always_comb begin
    st_nxt = st_r;

    // address and data are taken independently, in either order
    if (st_r.awrdy && awvalid) begin
      st_nxt.aw_ok   = 1'b1;
      st_nxt.aw_addr = awaddr[7:0];
    end
    if (st_r.wrdy && wvalid) begin
      st_nxt.w_ok   = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // commit once both halves are held and no response is pending
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (addr_hit(st_r.aw_addr)) begin
        st_nxt.ctrl  = wmerge(st_r.ctrl, st_r.w_data, st_r.w_strb);
        st_nxt.bresp = RESP_OKAY;
      end else begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end

    // reads answer one cycle after the address is taken
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (st_r.arrdy && arvalid) begin
      st_nxt.rvalid = 1'b1;
      if (addr_hit(araddr[7:0])) begin
        st_nxt.rdata = st_r.ctrl & ~RSV_MASK;
        st_nxt.rresp = RESP_OKAY;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = RESP_SLVERR;
      end
    end

    // ready flags are registered so every output comes from a flop
    st_nxt.awrdy = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wrdy  = !st_nxt.w_ok && !st_nxt.bvalid;
    st_nxt.arrdy = !st_nxt.rvalid;

    // a 1-then-0 on the load bit moves both counts to the lines
    st_nxt.load_q = st_r.ctrl[LOAD_BIT];
    st_nxt.load   = st_r.load_q && !st_r.ctrl[LOAD_BIT];
    if (st_r.load_q && !st_r.ctrl[LOAD_BIT]) begin
      st_nxt.tap_diff = st_r.ctrl[DIFF_TAP_LSB +: 9];
      st_nxt.tap_se   = st_r.ctrl[SE_TAP_LSB +: 9];
    end

    // two flops per input; only the second feeds the history
    st_nxt.s_diff = {st_r.s_diff[0], sync_diff_tapped};
    st_nxt.s_se   = {st_r.s_se[0], sync_se_tapped};
    st_nxt.h_diff = {st_r.h_diff[1:0], st_r.s_diff[1]};
    st_nxt.h_se   = {st_r.h_se[1:0], st_r.s_se[1]};

    // whole-cycle delay applied after the tap stage
    st_nxt.out_diff = pick(st_r.s_diff[1], st_r.h_diff,
                           st_r.ctrl[DIFF_CYC_LSB +: 2]);
    st_nxt.out_se   = pick(st_r.s_se[1], st_r.h_se,
                           st_r.ctrl[SE_CYC_LSB +: 2]);
  end

  // state register; the control word starts with the load bit low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign awready               = st_r.awrdy;
  assign wready                = st_r.wrdy;
  assign bvalid                = st_r.bvalid;
  assign bresp                 = st_r.bresp;
  assign arready               = st_r.arrdy;
  assign rvalid                = st_r.rvalid;
  assign rdata                 = st_r.rdata;
  assign rresp                 = st_r.rresp;
  assign tap_diff_value        = st_r.tap_diff;
  assign tap_se_value          = st_r.tap_se;
  assign tap_load_strobe       = st_r.load;
  assign pulse_per_second_diff = st_r.out_diff;
  assign pulse_per_second_se   = st_r.out_se;

  // checks on the design's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_se_cycle_delay;
    $past(st_r.ctrl[SE_CYC_LSB +: 2]) == 2'h2 |->
      st_r.out_se == $past(st_r.s_se[1], 3);
  endproperty
  a_se_cycle_delay: assert property (p_se_cycle_delay)
    else $error("single-ended input not delayed by two cycles");

  property p_se_tap_write;
    $rose(st_r.bvalid) && $past(st_r.w_strb) == 4'hf &&
      $past(addr_hit(st_r.aw_addr)) |->
      st_r.ctrl[SE_TAP_LSB +: 9] == $past(st_r.w_data[SE_TAP_LSB +: 9]);
  endproperty
  a_se_tap_write: assert property (p_se_tap_write)
    else $error("single-ended tap count not stored");

  property p_diff_cycle_delay;
    $past(st_r.ctrl[DIFF_CYC_LSB +: 2]) == 2'h0 |->
      st_r.out_diff == $past(st_r.s_diff[1]);
  endproperty
  a_diff_cycle_delay: assert property (p_diff_cycle_delay)
    else $error("differential input delay wrong for zero cycles");

  property p_diff_tap_write;
    $rose(st_r.bvalid) && $past(st_r.w_strb) == 4'hf &&
      $past(addr_hit(st_r.aw_addr)) |->
      st_r.ctrl[DIFF_TAP_LSB +: 9] == $past(st_r.w_data[DIFF_TAP_LSB +: 9]);
  endproperty
  a_diff_tap_write: assert property (p_diff_tap_write)
    else $error("differential tap count not stored");

  property p_load_seq;
    $fell(st_r.ctrl[LOAD_BIT]) |=>
      st_r.load && st_r.tap_diff == $past(st_r.ctrl[8:0]) ##1 !st_r.load;
  endproperty
  a_load_seq: assert property (p_load_seq)
    else $error("load strobe missing after 1-then-0");

  property p_tap_hold;
    !st_r.load |-> $stable(st_r.tap_se) && $stable(st_r.tap_diff);
  endproperty
  a_tap_hold: assert property (p_tap_hold)
    else $error("delay line taps changed without a load");

  property p_rsv_zero;
    st_r.rvalid |-> (st_r.rdata & RSV_MASK) == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bits read back non-zero");

  // further cycle settings (se 0 and 3, diff 1 and 3); each added cycle reaches back one more history stage
  property p_se_delay_zero;
    $past(st_r.ctrl[SE_CYC_LSB +: 2]) == 2'h0 |->
      st_r.out_se == $past(st_r.s_se[1]);
  endproperty
  a_se_delay_zero: assert property (p_se_delay_zero)
    else $error("single-ended input delay wrong for zero cycles");

  property p_se_delay_three;
    $past(st_r.ctrl[SE_CYC_LSB +: 2]) == 2'h3 |->
      st_r.out_se == $past(st_r.s_se[1], 4);
  endproperty
  a_se_delay_three: assert property (p_se_delay_three)
    else $error("single-ended input delay wrong for three cycles");

  property p_diff_delay_one;
    $past(st_r.ctrl[DIFF_CYC_LSB +: 2]) == 2'h1 |->
      st_r.out_diff == $past(st_r.s_diff[1], 2);
  endproperty
  a_diff_delay_one: assert property (p_diff_delay_one)
    else $error("differential input delay wrong for one cycle");

  property p_diff_delay_three;
    $past(st_r.ctrl[DIFF_CYC_LSB +: 2]) == 2'h3 |->
      st_r.out_diff == $past(st_r.s_diff[1], 4);
  endproperty
  a_diff_delay_three: assert property (p_diff_delay_three)
    else $error("differential input delay wrong for three cycles");

  // a strobe only ever follows a 1 and then a 0 on the load bit
  property p_load_after_fall;
    st_r.load |->
      $past(st_r.ctrl[LOAD_BIT], 2) && !$past(st_r.ctrl[LOAD_BIT]);
  endproperty
  a_load_after_fall: assert property (p_load_after_fall)
    else $error("load strobe without a 1-then-0 on the load bit");

  property p_load_single;
    st_r.load |=> !st_r.load;
  endproperty
  a_load_single: assert property (p_load_single)
    else $error("load strobe stood longer than one cycle");

  property p_se_tap_load;
    $fell(st_r.ctrl[LOAD_BIT]) |=>
      st_r.tap_se == $past(st_r.ctrl[SE_TAP_LSB +: 9]);
  endproperty
  a_se_tap_load: assert property (p_se_tap_load)
    else $error("single-ended tap count not moved on load");

  property p_rsv_store;
    (st_r.ctrl & RSV_MASK) == 32'h0000_0000;
  endproperty
  a_rsv_store: assert property (p_rsv_store)
    else $error("reserved bits held non-zero in the control word");

endmodule

// ===== dv/sidc_sync_line.sv
// far-side delay line model: takes a tap count on the load pulse and
// delays the sync input by the matching span, transport style
`timescale 1ns/1ps
module sidc_sync_line
  import sidc_pkg::*;
(
  input  wire logic       tap_load_strobe,
  input  wire logic [8:0] tap_value,
  input  wire logic       sync_in,
  output logic            sync_out
);
  real dly_ns = TAP_MIN_PS / 1000.0;

  // taken on the falling side so the tap count has surely settled
  always @(negedge tap_load_strobe) begin
    dly_ns = (TAP_MIN_PS + tap_value * (TAP_MAX_PS - TAP_MIN_PS) /
              (TAP_COUNT - 1.0)) / 1000.0;
  end

  // transport delay, so short pulses are not swallowed
  initial sync_out = 1'b0;
  always @(sync_in) sync_out <= #(dly_ns) sync_in;
endmodule

// ===== dv/sidc_bench.sv
// register and sync path tests for the sync input delay control
// assumes two delay line models stand between the sources and the block
`timescale 1ns/1ps
module sidc_bench;
  import sidc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, tap_load_strobe;
  logic        src_d, src_s, sync_diff_tapped, sync_se_tapped;
  logic [8:0]  tap_diff_value, tap_se_value, cap_d, cap_s;
  logic        pulse_per_second_diff, pulse_per_second_se;
  int          n_fail, num_checks, n_ld, t_d, t_s;

  sidc_top u_sidc_top (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sync_diff_tapped, .sync_se_tapped, .tap_diff_value,
    .tap_se_value, .tap_load_strobe, .pulse_per_second_diff,
    .pulse_per_second_se);
  sidc_sync_line u_line_d (.tap_load_strobe, .tap_value(tap_diff_value),
    .sync_in(src_d), .sync_out(sync_diff_tapped));
  sidc_sync_line u_line_s (.tap_load_strobe, .tap_value(tap_se_value),
    .sync_in(src_s), .sync_out(sync_se_tapped));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // strobe stands one cycle; read mid-cycle where it has settled
  always @(negedge aclk) begin
    if (tap_load_strobe === 1'b1) begin
      n_ld++;
      cap_d = tap_diff_value;
      cap_s = tap_se_value;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // each half released once taken; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    logic aw_p, w_p, aw_t, w_t, got;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // readies read settled after one edge, for the edge that follows
    while (aw_p || w_p) begin
      #1;
      aw_t = aw_p && awready === 1'b1;
      w_t = w_p && wready === 1'b1;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      aw_p = aw_p && !aw_t;
      w_p = w_p && !w_t;
    end
    do begin
      #1;
      got = bvalid === 1'b1;
      rs = bresp;
      @(posedge aclk);
    end while (!got);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic got;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      #1;
      got = arready === 1'b1;
      @(posedge aclk);
    end while (!got);
    arvalid <= 1'b0;
    // data taken as it stands at the edge that completes the read
    do begin
      #1;
      got = rvalid === 1'b1;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
    end while (!got);
    rready <= 1'b0;
  endtask

  // launch a pulse on both inputs and count edges until each output
  task automatic pulse;
    @(posedge aclk);
    src_d <= 1'b1; src_s <= 1'b1; t_d = 0; t_s = 0;
    for (int i = 1; i <= 9; i++) begin
      @(posedge aclk);
      #1;
      if (pulse_per_second_diff === 1'b1 && t_d == 0) t_d = i;
      if (pulse_per_second_se === 1'b1 && t_s == 0) t_s = i;
    end
    src_d <= 1'b0; src_s <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run is a couple of hundred cycles
  initial begin
    #200us;
    n_fail++;
    conclude;
  end

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0; src_d = 1'b0; src_s = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(CTRL_OFFSET);
    chk("reset word", CTRL_RESET, rd);
    wr(CTRL_OFFSET, 32'hffff_ffff);
    chk("bresp", RESP_OKAY, rs);
    rdr(CTRL_OFFSET);
    chk("masked word", ~RSV_MASK, rd);
    chk("taps before load", 9'h000, tap_diff_value);
    wr(CTRL_OFFSET, 32'h01ff_01ff);
    repeat (4) @(posedge aclk);
    chk("loads", 1, n_ld);
    chk("diff taps", 9'h1ff, cap_d);
    chk("se taps", 9'h1ff, cap_s);
    wr(CTRL_OFFSET, 32'h0000_0200);
    chk("taps held", 9'h1ff, tap_se_value);
    wr(CTRL_OFFSET, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk("loads", 2, n_ld);
    chk("diff taps", 9'h000, cap_d);
    $display("register tests done");
    wr(8'h08, 32'hffff_ffff);
    chk("unmapped bresp", RESP_SLVERR, rs);
    rdr(8'h08);
    chk("unmapped rresp", RESP_SLVERR, rs);
    chk("unmapped rdata", 32'h0, rd);
    rdr(CTRL_OFFSET);
    chk("word kept", 32'h0, rd);
    wr(CTRL_OFFSET, 32'hffff_ffff, 4'h4);
    rdr(CTRL_OFFSET);
    chk("strobed word", 32'h00ff_0000, rd);
    $display("unmapped tests done");
    for (int d = 0; d < 4; d++) begin
      wr(CTRL_OFFSET, (32'(3 - d) << SE_CYC_LSB) | (32'(d) << DIFF_CYC_LSB));
      pulse;
      // two sampling flops and the output flop give three cycles at zero
      chk("diff delay", 3 + d, t_d);
      chk("se delay", 6 - d, t_s);
    end
    $display("sync delay tests done");
    conclude;
  end
endmodule
